// [core/wdt_defs.svh]
// Offsets, field positions, reset values and timing counts of the watchdog timer.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Register frame base and word addresses.
`define WDT_FRAME_BASE 16'h7020
`define WDT_COUNTER_ADDR 16'h7023
`define WDT_KEY_ADDR 16'h7025
`define WDT_CTRL_ADDR 16'h7029
`define WDT_SYSCTL2_ADDR 16'h7019

// Control register fields.
`define WDT_CTRL_FLAG_BIT 7
`define WDT_CTRL_DIS_BIT 6
`define WDT_CTRL_CHK_HI 5
`define WDT_CTRL_CHK_LO 3
`define WDT_CTRL_PS_HI 2
`define WDT_CTRL_PS_LO 0
`define WDT_CHECK_PATTERN 3'h5
`define WDT_CTRL_RESET 8'h00

// Second system control register field.
`define WDT_SYSCTL2_WDEN_BIT 5
`define WDT_SYSCTL2_RESET 8'h00

// Service key values.
`define WDT_KEY_ARM 8'h55
`define WDT_KEY_FIRE 8'haa

// Base clock divider and reset pulse length.
`define WDT_BASE_DIV 512
`define WDT_BASE_DIV_W 9
`define WDT_PRE_W 6
`define WDT_RESET_PULSE 8'h0f

`endif

// [core/wdt_pkg.sv]
// Types shared by the watchdog timer.
`default_nettype none

package wdt_pkg;

    typedef enum logic [2:0]
    {
        WDT_RUN = 3'h1,
        WDT_ARMED = 3'h2,
        WDT_FIRE = 3'h4
    } wdt_state_t;

endpackage : wdt_pkg

`default_nettype wire

// [core/wdt_timer.sv]
// Watchdog timer with service key, check bits and system reset request.
//
// Chosen here: the address map and the strobed register port.
`default_nettype none
`include "wdt_defs.svh"

module wdt_timer
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // System reset request and status.
    output logic sys_reset_req,
    output logic wd_running
);

    logic [`WDT_BASE_DIV_W-1:0] base_cnt_reg;
    logic [`WDT_PRE_W-1:0] pre_cnt_reg;
    logic [7:0] count_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] sysctl2_reg;
    logic [7:0] pulse_reg;
    logic [7:0] rdata_reg;
    wdt_pkg::wdt_state_t state_reg;
    wdt_pkg::wdt_state_t state_next;

    // Address decode and write strobes; only the low byte is ever used.
    wire logic sel_cnt = reg_addr == `WDT_COUNTER_ADDR;
    wire logic sel_key = reg_addr == `WDT_KEY_ADDR;
    wire logic sel_ctrl = reg_addr == `WDT_CTRL_ADDR;
    wire logic sel_sc2 = reg_addr == `WDT_SYSCTL2_ADDR;
    wire logic wr_key = reg_wr && sel_key;
    wire logic wr_ctrl = reg_wr && sel_ctrl;
    wire logic wr_sc2 = reg_wr && sel_sc2;
    wire logic [7:0] wbyte = reg_wdata[7:0];

    // Disable takes effect only while the system-level permission bit is set.
    wire logic disabled = ctrl_reg[`WDT_CTRL_DIS_BIT]
        && sysctl2_reg[`WDT_SYSCTL2_WDEN_BIT];
    wire logic active = !disabled && state_reg != wdt_pkg::WDT_FIRE;

    // Base tick: device clock divided by 512.
    wire logic base_tick = base_cnt_reg == `WDT_BASE_DIV_W'(`WDT_BASE_DIV - 1);

    // Prescale terminal count per select code.
    wire logic [2:0] ps_sel = ctrl_reg[`WDT_CTRL_PS_HI:`WDT_CTRL_PS_LO];
    logic [`WDT_PRE_W-1:0] pre_top;
    always_comb
    begin
        case (ps_sel)
            3'h0, 3'h1: pre_top = 6'h00;
            3'h2: pre_top = 6'h01;
            3'h3: pre_top = 6'h03;
            3'h4: pre_top = 6'h07;
            3'h5: pre_top = 6'h0f;
            3'h6: pre_top = 6'h1f;
            default: pre_top = 6'h3f;
        endcase
    end
    wire logic wd_tick = base_tick && pre_cnt_reg >= pre_top;

    // Key sequencing and fault causes.
    wire logic key_arm = wr_key && wbyte == `WDT_KEY_ARM;
    wire logic key_fire = wr_key && wbyte == `WDT_KEY_FIRE
        && state_reg == wdt_pkg::WDT_ARMED;
    wire logic key_bad = wr_key && !key_arm && !key_fire;
    wire logic chk_bad = wr_ctrl
        && wbyte[`WDT_CTRL_CHK_HI:`WDT_CTRL_CHK_LO] != `WDT_CHECK_PATTERN;
    wire logic overflow = active && wd_tick && count_reg == 8'hff;
    wire logic fault = key_bad || chk_bad || overflow;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            wdt_pkg::WDT_RUN:
            begin
                if (fault)
                    state_next = wdt_pkg::WDT_FIRE;
                else if (key_arm)
                    state_next = wdt_pkg::WDT_ARMED;
            end
            wdt_pkg::WDT_ARMED:
            begin
                if (fault)
                    state_next = wdt_pkg::WDT_FIRE;
                else if (key_fire)
                    state_next = wdt_pkg::WDT_RUN;
            end
            wdt_pkg::WDT_FIRE:
            begin
                if (pulse_reg == 8'h00)
                    state_next = wdt_pkg::WDT_RUN;
            end
            default: state_next = wdt_pkg::WDT_RUN;
        endcase
    end

    // Read mux; the flag bit shows that the last reset came from this block.
    logic [7:0] rmux;
    always_comb
    begin
        rmux = 8'h00;
        if (sel_cnt)
            rmux = count_reg;
        else if (sel_ctrl)
            rmux = ctrl_reg;
        else if (sel_sc2)
            rmux = sysctl2_reg;
    end

    // Prescale and base dividers free-run from reset release.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_cnt_reg <= '0;
            pre_cnt_reg <= '0;
        end
        else
        begin
            base_cnt_reg <= base_cnt_reg + `WDT_BASE_DIV_W'(1);
            if (wd_tick)
                pre_cnt_reg <= '0;
            else if (base_tick)
                pre_cnt_reg <= pre_cnt_reg + 6'h01;
        end
    end

    // Watchdog counter: clear wins over increment.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= 8'h00;
        else if (key_fire || state_reg == wdt_pkg::WDT_FIRE)
            count_reg <= 8'h00;
        else if (active && wd_tick)
            count_reg <= count_reg + 8'h01;
    end

    // Control registers; a reset from this block also restores fastest rate.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `WDT_CTRL_RESET;
            sysctl2_reg <= `WDT_SYSCTL2_RESET;
        end
        else if (fault)
            ctrl_reg <= 8'h80 | `WDT_CTRL_RESET;
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= {ctrl_reg[7] & ~wbyte[7], wbyte[6:0]};
            if (wr_sc2)
                sysctl2_reg <= wbyte;
        end
    end

    // Reset request pulse and status outputs.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= wdt_pkg::WDT_RUN;
            pulse_reg <= 8'h00;
            sys_reset_req <= 1'b0;
            wd_running <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            if (fault && state_reg != wdt_pkg::WDT_FIRE)
                pulse_reg <= `WDT_RESET_PULSE;
            else if (pulse_reg != 8'h00)
                pulse_reg <= pulse_reg - 8'h01;
            sys_reset_req <= state_next == wdt_pkg::WDT_FIRE;
            wd_running <= !disabled;
            rdata_reg <= reg_rd ? rmux : 8'h00;
        end
    end

    assign reg_rdata = {8'h00, rdata_reg};

endmodule : wdt_timer

`default_nettype wire

// [tb/wdt_timer_chk.sv]
// Port assertions for the watchdog timer.
`default_nettype none
`include "wdt_defs.svh"
module wdt_timer_chk
(
    // Clock, reset and register port.
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    // Observed outputs.
    input wire logic [15:0] reg_rdata,
    input wire logic sys_reset_req,
    input wire logic wd_running
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic key_wr = reg_wr && reg_addr == `WDT_KEY_ADDR && !sys_reset_req;
    wire logic ctl_wr = reg_wr && reg_addr == `WDT_CTRL_ADDR && !sys_reset_req;
    wire logic [7:0] wd = reg_wdata[7:0];
    sequence held8;
        sys_reset_req [*8];
    endsequence
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not idle");
    upper_zero_a: assert property (reg_rdata[15:8] == 8'h00)
        else $error("upper byte not zero");
    bad_key_a: assert property (key_wr && wd != `WDT_KEY_ARM && wd != `WDT_KEY_FIRE
        |=> sys_reset_req) else $error("wrong key without reset");
    arm_key_a: assert property (key_wr && wd == `WDT_KEY_ARM |=> !sys_reset_req)
        else $error("arming key caused reset");
    bad_check_a: assert property (ctl_wr && reg_wdata[5:3] != `WDT_CHECK_PATTERN
        |=> sys_reset_req) else $error("bad check bits without reset");
    pulse_len_a: assert property ($rose(sys_reset_req) |-> held8 ##1 held8 ##1 !sys_reset_req)
        else $error("reset pulse length wrong");
    stay_on_a: assert property ($past(wd_running) && !$past(reg_wr) && !$past(reg_wr, 2) |-> wd_running)
        else $error("watchdog stopped without a write");
    unmapped_a: assert property (reg_rd && reg_addr == `WDT_FRAME_BASE |=> reg_rdata == 0)
        else $error("unmapped read not zero");
endmodule : wdt_timer_chk
bind wdt_timer wdt_timer_chk u_chk
(
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sys_reset_req(sys_reset_req), .wd_running(wd_running)
);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the watchdog timer.
`default_nettype none
`include "wdt_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic sys_reset_req;
    logic wd_running;
    logic [15:0] v;
    int errors = 0;
    int n_tests = 0;
    wdt_timer u_dut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sys_reset_req(sys_reset_req), .wd_running(wd_running)
    );
    initial forever #10 sys_clk = ~sys_clk;
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // A fault write must raise the request, which then has to drop within a bounded time.
    task automatic fault(input logic [15:0] a, input logic [15:0] d);
        wr(a, d);
        #1 check("reset request", 16'h0001, {15'h0, sys_reset_req});
        for (int i = 0; i < 40 && sys_reset_req !== 1'b0; i++)
            #20;
        if (sys_reset_req !== 1'b0)
        begin
            errors++;
            report_and_stop();
        end
        rd(`WDT_CTRL_ADDR);
        check("ctrl after fault", 16'h0080, v);
    endtask : fault
    task automatic t_reset();
        rd(`WDT_CTRL_ADDR);
        check("ctrl at reset", 16'h0000, v);
        rd(`WDT_FRAME_BASE);
        check("unmapped", 16'h0000, v);
        check("running", 16'h0001, {15'h0, wd_running});
        $display("test reset done");
    endtask : t_reset
    task automatic t_rates();
        for (int p = 0; p < 8; p++)
        begin
            wr(`WDT_CTRL_ADDR, 16'hff28 | 16'(p));
            rd(`WDT_CTRL_ADDR);
            check("rate select", 16'h0028 | 16'(p), v);
        end
        check("no reset", 16'h0000, {15'h0, sys_reset_req});
        $display("test rates done");
    endtask : t_rates
    task automatic t_service();
        wr(`WDT_CTRL_ADDR, 16'h0028);
        wr(`WDT_KEY_ADDR, 16'h0055);
        wr(`WDT_KEY_ADDR, 16'h00aa);
        repeat (1100) @(posedge sys_clk);
        rd(`WDT_COUNTER_ADDR);
        check("count moving", 16'h0001, {15'h0, v >= 16'h2 && v <= 16'h3});
        wr(`WDT_KEY_ADDR, 16'h0055);
        wr(`WDT_KEY_ADDR, 16'h00aa);
        rd(`WDT_COUNTER_ADDR);
        check("count cleared", 16'h0000, v);
        check("no reset", 16'h0000, {15'h0, sys_reset_req});
        $display("test service done");
    endtask : t_service
    task automatic t_faults();
        fault(`WDT_KEY_ADDR, 16'h00aa);
        fault(`WDT_KEY_ADDR, 16'h0012);
        fault(`WDT_CTRL_ADDR, 16'h0030);
        $display("test faults done");
    endtask : t_faults
    task automatic t_disable();
        wr(`WDT_CTRL_ADDR, 16'h0068);
        @(posedge sys_clk);
        #1 check("not disabled", 16'h0001, {15'h0, wd_running});
        wr(`WDT_SYSCTL2_ADDR, 16'h0020);
        wr(`WDT_CTRL_ADDR, 16'h0068);
        @(posedge sys_clk);
        #1 check("disabled", 16'h0000, {15'h0, wd_running});
        $display("test disable done");
    endtask : t_disable
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_rates();
        t_service();
        t_faults();
        t_disable();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
